//--- inc/acrp_pkg.sv
// Constants, types and helper functions for the ATM cell receive path.
// Assumes one system clock; framing overhead bits are gated off upstream.
// Behaviour
// - Answer any programmed port address 0..31
// - Cell available while FIFO holds a cell
// - Cell available low one cycle after transfer
// - Check header code with 1+X+X^2+X^8
// - Subtract 0x55 offset unless control bit 0 clear
// - Search bitwise, found header enters pre-lock
// - Six good checks lock, one bad searches
// - Seven bad checks in lock return to search
// - Integrate out-of-delineation into delineation loss
// - Masked interrupt on every delineation loss change
// - Correct only when enabled, locked, correction mode
// - Correct single bit then detect; good header restores
// - Saturating 8-bit corrected, 12-bit uncorrectable counters
// - Optional X^43+1 payload descrambling while synchronised
// - Write FIFO only locked and not full; filter
// - Drop uncorrectable cells unless override bit set
// - Saturating 16-bit eligible cell count, latch clears
// - 2k x 8 FIFO, four cells per port
// - Cell available held through the transfer
// - Selection samples address only while enable deasserted
package acrp_pkg;
	localparam int		AXI_AW      = 8;		// Register byte address width
	localparam logic [7:0]	OFF_CTRL_A  = 8'h00;		// rx_cell_control_a
	localparam logic [7:0]	OFF_CTRL_B  = 8'h04;		// rx_cell_control_b
	localparam logic [7:0]	OFF_PORT    = 8'h08;		// Port address and poll mode
	localparam logic [7:0]	OFF_INTEG   = 8'h0C;		// Integration period
	localparam logic [7:0]	OFF_STATUS  = 8'h10;		// Delineation status
	localparam logic [7:0]	OFF_HECCNT  = 8'h14;		// Header error counters
	localparam logic [7:0]	OFF_LATCH   = 8'h18;		// Cell count latch
	localparam int		CB_MASK     = 4;		// Interrupt enable in control b
	localparam int		ST_CHG      = 3;		// Sticky change bit in status
	localparam logic [7:0]	CTRL_A_RST  = 8'h03;		// Offset and correction on
	localparam logic [7:0]	CTRL_B_RST  = 8'h00;
	localparam logic [15:0]	INTEG_RST   = 16'h0010;		// Ticks of persistence
	localparam logic [1:0]	RESP_OKAY   = 2'h0;
	localparam logic [1:0]	RESP_SLVERR = 2'h2;
	localparam logic [7:0]	HEC_POLY    = 8'h07;		// X^8 term implied
	localparam logic [7:0]	HEC_OFFSET  = 8'h55;
	localparam logic [8:0]	HDR_END     = 9'h027;		// Bit index of last header bit
	localparam logic [8:0]	LAST_BIT    = 9'h1A7;		// 424 bits per cell
	localparam logic [2:0]	LOCK_CHECKS = 3'h6;
	localparam logic [2:0]	LOSS_CHECKS = 3'h7;
	localparam int		DESCR_LEN   = 43;
	localparam logic [31:0]	IDLE_HDR    = 32'h00000001;
	localparam logic [5:0]	CELL_BYTES  = 6'h35;		// 53 bytes
	localparam logic [2:0]	HDR_BYTES   = 3'h5;
	localparam logic [2:0]	FIFO_CELLS  = 3'h4;
	localparam int		MEM_AW      = 11;		// 2k bytes
	localparam logic [2:0]	MEM_PORT    = 3'h0;		// This port's region
	localparam int		PRESCALE_DIV = 16383;
	localparam logic [15:0]	CORR_MAX    = 16'h00FF;
	localparam logic [15:0]	UNCORR_MAX  = 16'h0FFF;
	localparam logic [15:0]	CELL_MAX    = 16'hFFFF;

	typedef enum logic [1:0] {search_state, pre_lock_state, locked_state} acrp_delin_t;
	typedef enum logic {corr_mode, detect_mode} acrp_hmode_t;

	// Fields of rx_cell_control_a, bit 0 at the bottom
	typedef struct packed {
		logic	unas_drop;
		logic	idle_drop;
		logic	ovrd;
		logic	descr_en;
		logic	corr_en;
		logic	hdr_offs_en;
	} acrp_ctrl_t;

	// Header check code over four header bytes
	function automatic logic [7:0] hec_calc(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? HEC_POLY : 8'h00);
		return c;
	endfunction

	// Whole header valid, offset removed when enabled
	function automatic logic hec_good(input logic [39:0] h, input logic cs);
		return hec_calc(h[39:8]) == (h[7:0] ^ (cs ? HEC_OFFSET : 8'h00));
	endfunction

	// Search for a single flipped bit; top bit flags success
	function automatic logic [40:0] hec_fix(input logic [39:0] h, input logic cs);
		logic [40:0] r;
		r = {1'b0, h};
		for (int i = 0; i < 40; i++)
			if (!r[40] && hec_good(h ^ (40'h1 << i), cs))
				r = {1'b1, h ^ (40'h1 << i)};
		return r;
	endfunction

	// Saturating counter step; a same-cycle count survives a clear as 1
	function automatic logic [15:0] cnt_step(input logic [15:0] v, input logic [15:0] top,
		input logic inc, input logic clr);
		if (clr)
			return inc ? 16'h0001 : 16'h0000;
		return (inc && v != top) ? v + 16'h0001 : v;
	endfunction
endpackage

//--- verilog/acrp_cell_ram.sv
// Byte memory for the receive cell FIFO, one write and one read port.
// Assumes the caller keeps slot accounting; read data is registered.
`timescale 1ns/10ps
module acrp_cell_ram
	(
	input	wire logic				clk,
	input	wire logic				rst_n,
	input	wire logic				we,
	input	wire logic [acrp_pkg::MEM_AW-1:0]	waddr,
	input	wire logic [7:0]			wdata,
	input	wire logic				re,
	input	wire logic [acrp_pkg::MEM_AW-1:0]	raddr,
	output	logic [7:0]				rdata_ff
	);
	import acrp_pkg::*;

	logic [7:0]	mem [0:(1<<MEM_AW)-1];	// No reset, contents only read once written

	// Array write, kept apart so it maps onto plain RAM
	always_ff @(posedge clk)
		if (we)
			mem[waddr] <= wdata;

	// Read register drives the cell bus directly
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			rdata_ff <= 8'h00;
		else if (re)
			rdata_ff <= mem[raddr];
endmodule // acrp_cell_ram

//--- verilog/acrp_rx_path.sv
// Receive cell path: delineation, header correction, descrambling, FIFO and cell bus.
// Assumes synchronous line bits with overhead gated by LINE_BIT_VALID, AXI4-Lite host.
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module acrp_rx_path
	#(
	parameter int PRESCALE_CYCLES = acrp_pkg::PRESCALE_DIV	// Persistence sampling divider
	)
	(
	input	wire logic				CLK,
	input	wire logic				RST_N,
	input	wire logic				LINE_BIT,
	input	wire logic				LINE_BIT_VALID,
	input	wire logic [4:0]			UR_ADDR,
	input	wire logic				UR_ENB_N,
	output	logic					UR_CLAV,
	output	logic					UR_CLAV_OE,
	output	logic [7:0]				UR_DATA,
	output	logic					UR_DATA_OE,
	output	logic					UR_SOC,
	output	logic					LOSS_IRQ,
	input	wire logic [acrp_pkg::AXI_AW-1:0]	S_AXI_AWADDR,
	input	wire logic				S_AXI_AWVALID,
	output	logic					S_AXI_AWREADY,
	input	wire logic [31:0]			S_AXI_WDATA,
	input	wire logic [3:0]			S_AXI_WSTRB,
	input	wire logic				S_AXI_WVALID,
	output	logic					S_AXI_WREADY,
	output	logic [1:0]				S_AXI_BRESP,
	output	logic					S_AXI_BVALID,
	input	wire logic				S_AXI_BREADY,
	input	wire logic [acrp_pkg::AXI_AW-1:0]	S_AXI_ARADDR,
	input	wire logic				S_AXI_ARVALID,
	output	logic					S_AXI_ARREADY,
	output	logic [31:0]				S_AXI_RDATA,
	output	logic [1:0]				S_AXI_RRESP,
	output	logic					S_AXI_RVALID,
	input	wire logic				S_AXI_RREADY
	);
	import acrp_pkg::*;

	localparam int PW = $clog2(PRESCALE_CYCLES);

	// Software state
	logic [7:0]	ctrl_a_ff;		// Receive options
	logic [7:0]	ctrl_b_ff;		// Interrupt enable
	logic [4:0]	port_ff;		// Cell bus address
	logic		dir_ff;			// Direct status poll mode
	logic [15:0]	integ_ff;		// Integration period in ticks
	logic		chg_ff;			// Sticky loss change
	logic		bvalid_ff;
	logic [1:0]	bresp_ff;
	logic		rvalid_ff;
	logic [31:0]	rdata_ff;
	logic [1:0]	rresp_ff;
	// Line side state
	logic [39:0]	sr_ff;			// Last 40 line bits
	logic [8:0]	bit_ff;			// Bit position in cell
	logic [2:0]	run_ff;			// Consecutive check count
	acrp_delin_t	st_ff;
	acrp_hmode_t	mode_ff;
	logic [DESCR_LEN-1:0] ds_ff;		// Descrambler history
	logic [7:0]	pay_sr_ff;		// Payload byte assembly
	logic		wact_ff;		// Cell being written
	logic [1:0]	wslot_ff;
	logic [39:0]	hdr_q_ff;		// Header bytes still to write
	logic [2:0]	hidx_ff;
	logic [2:0]	cnt_ff;			// Committed cells
	logic [7:0]	corr_ff;
	logic [11:0]	uncorr_ff;
	logic [15:0]	cells_ff;
	logic [15:0]	latched_ff;
	logic [PW-1:0]	pre_ff;			// Persistence prescaler
	logic [15:0]	per_ff;			// Persistence run
	logic		loss_ff;
	// Cell bus state
	logic		sel_ff;
	logic		poll_ff;
	logic		xfer_ff;
	logic		hold_ff;
	logic [5:0]	ridx_ff;
	logic [1:0]	rslot_ff;
	logic		soc_ff;
	logic		doe_ff;
	logic [7:0]	ram_q;
	acrp_delin_t	nxt_st;
	logic [2:0]	nxt_run;
	logic [8:0]	nxt_bit;

	acrp_ctrl_t	ctl;
	assign ctl = acrp_ctrl_t'(ctrl_a_ff[5:0]);

	// Bus write decode; address and data are taken together
	wire		wr_go   = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_ff;
	wire [7:0]	waddr   = {S_AXI_AWADDR[7:2], 2'h0};
	wire		w_a     = wr_go && waddr == OFF_CTRL_A;
	wire		w_b     = wr_go && waddr == OFF_CTRL_B;
	wire		w_port  = wr_go && waddr == OFF_PORT;
	wire		w_integ = wr_go && waddr == OFF_INTEG;
	wire		w_stat  = wr_go && waddr == OFF_STATUS;
	wire		w_hec   = wr_go && waddr == OFF_HECCNT;
	wire		w_latch = wr_go && waddr == OFF_LATCH;
	wire		wr_hit  = w_a | w_b | w_port | w_integ | w_stat | w_hec | w_latch;
	wire		ar_go   = S_AXI_ARVALID && !rvalid_ff;
	wire [7:0]	raddr   = {S_AXI_ARADDR[7:2], 2'h0};

	// Line side decode
	wire		bit_in   = LINE_BIT_VALID;		// Overhead bits never reach the checker
	wire [39:0]	sr_nxt   = {sr_ff[38:0], LINE_BIT};
	wire		good_now = hec_good(sr_nxt, ctl.hdr_offs_en);	// Offset removal switchable
	wire [8:0]	bit_inc  = (bit_ff == LAST_BIT) ? 9'h000 : bit_ff + 9'h001;
	wire		synced   = st_ff != search_state;
	wire		at_hdr   = bit_in && synced && bit_inc == HDR_END;
	wire		at_lock  = at_hdr && st_ff == locked_state && nxt_st == locked_state;
	// Header repair and filtering
	wire [40:0]	fixr     = hec_fix(sr_nxt, ctl.hdr_offs_en);
	wire		hdr_err  = !good_now;
	wire		can_fix  = hdr_err && ctl.corr_en && mode_ff == corr_mode && fixr[40];
	wire [39:0]	hdr_fix  = can_fix ? fixr[39:0] : sr_nxt;
	wire		uncorr   = hdr_err && !can_fix;		// Correction off makes all errors fatal
	wire		is_idle  = hdr_fix[39:8] == IDLE_HDR;
	wire		is_unas  = hdr_fix[39:12] == 28'h0000000 && !hdr_fix[8];
	wire		keep     = (!uncorr || ctl.ovrd) && !(ctl.idle_drop && is_idle)
				&& !(ctl.unas_drop && is_unas);
	wire		take     = at_lock && keep;
	wire		start_wr = take && cnt_ff != FIFO_CELLS;	// Full FIFO drops the cell
	// Payload path
	wire		pay_bit  = bit_in && synced && bit_inc > HDR_END;
	wire		desc_bit = ctl.descr_en ? LINE_BIT ^ ds_ff[DESCR_LEN-1] : LINE_BIT;
	wire		byte_rdy = pay_bit && bit_inc[2:0] == 3'h7;
	wire		hdr_wr   = wact_ff && hidx_ff != HDR_BYTES;
	wire		pay_wr   = wact_ff && byte_rdy && !hdr_wr;
	wire		commit   = pay_wr && bit_inc == LAST_BIT;
	wire		ram_we   = hdr_wr || pay_wr;
	wire [5:0]	widx     = hdr_wr ? {3'h0, hidx_ff} : bit_inc[8:3];
	wire [7:0]	wbyte    = hdr_wr ? hdr_q_ff[39:32] : {pay_sr_ff[6:0], desc_bit};
	// Counters
	wire [15:0]	corr_w   = cnt_step({8'h00, corr_ff}, CORR_MAX, at_lock && can_fix, w_hec);
	wire [15:0]	unc_w    = cnt_step({4'h0, uncorr_ff}, UNCORR_MAX, at_lock && uncorr, w_hec);
	wire [15:0]	cells_w  = cnt_step(cells_ff, CELL_MAX, take, w_latch);	// Counts even if full
	// Persistence
	wire		tick     = pre_ff == PW'(PRESCALE_CYCLES - 1);
	wire		ood      = st_ff != locked_state;
	wire		flip     = tick && ood != loss_ff && per_ff + 16'h0001 >= integ_ff;
	// Cell bus
	wire		addr_me  = UR_ADDR == port_ff;		// Any of 32 addresses
	wire		avail    = cnt_ff != 3'h0;
	wire		rd_go    = sel_ff && !UR_ENB_N && (xfer_ff || (avail && !hold_ff));
	wire		rd_last  = rd_go && ridx_ff == CELL_BYTES - 6'h01;

	// Delineation next state
	always_comb
	begin
		nxt_st  = st_ff;
		nxt_run = run_ff;
		nxt_bit = bit_ff;
		if (bit_in)
		begin
			nxt_bit = bit_inc;
			case (st_ff)
				search_state:		// Bit by bit search_state
				begin
					nxt_bit = HDR_END;
					nxt_run = 3'h0;
					if (good_now)
						nxt_st = pre_lock_state;
				end
				pre_lock_state:		// Cell by cell confirm
				begin
					if (at_hdr && hdr_err)
						nxt_st = search_state;
					else if (at_hdr && run_ff == LOCK_CHECKS - 3'h1)
					begin
						nxt_st  = locked_state;
						nxt_run = 3'h0;
					end
					else if (at_hdr)
						nxt_run = run_ff + 3'h1;
				end
				locked_state:		// Loss after repeated failures
				begin
					if (at_hdr && !hdr_err)
						nxt_run = 3'h0;
					else if (at_hdr && run_ff == LOSS_CHECKS - 3'h1)
						nxt_st = search_state;
					else if (at_hdr)
						nxt_run = run_ff + 3'h1;
				end
				default:
					nxt_st = search_state;
			endcase
		end
	end

	// Register file writes and response
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			ctrl_a_ff <= CTRL_A_RST;
			ctrl_b_ff <= CTRL_B_RST;
			port_ff   <= 5'h00;
			dir_ff    <= 1'b0;
			integ_ff  <= INTEG_RST;
			chg_ff    <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end
		else
		begin
			if (w_a && S_AXI_WSTRB[0])
				ctrl_a_ff <= S_AXI_WDATA[7:0];
			if (w_b && S_AXI_WSTRB[0])
				ctrl_b_ff <= S_AXI_WDATA[7:0];
			if (w_port && S_AXI_WSTRB[0])
				port_ff <= S_AXI_WDATA[4:0];
			if (w_port && S_AXI_WSTRB[1])
				dir_ff <= S_AXI_WDATA[8];
			if (w_integ && S_AXI_WSTRB[0])
				integ_ff[7:0] <= S_AXI_WDATA[7:0];
			if (w_integ && S_AXI_WSTRB[1])
				integ_ff[15:8] <= S_AXI_WDATA[15:8];
			// Change event beats a same-cycle clear
			chg_ff <= flip || (chg_ff && !(w_stat && S_AXI_WSTRB[0] && S_AXI_WDATA[ST_CHG]));
			if (wr_go)
				bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			if (wr_go)
				bvalid_ff <= 1'b1;
			else if (S_AXI_BREADY)
				bvalid_ff <= 1'b0;
		end

	// Read data selection
	logic [31:0]	rd_mux;
	logic		rd_hit;
	always_comb
	begin
		rd_hit = 1'b1;
		case (raddr)
			OFF_CTRL_A:	rd_mux = {24'h000000, ctrl_a_ff};
			OFF_CTRL_B:	rd_mux = {24'h000000, ctrl_b_ff};
			OFF_PORT:	rd_mux = {23'h000000, dir_ff, 3'h0, port_ff};
			OFF_INTEG:	rd_mux = {16'h0000, integ_ff};
			OFF_STATUS:	rd_mux = {27'h0000000, mode_ff == detect_mode, chg_ff, loss_ff, st_ff};
			OFF_HECCNT:	rd_mux = {4'h0, uncorr_ff, 8'h00, corr_ff};
			OFF_LATCH:	rd_mux = {16'h0000, latched_ff};
			default:
			begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read channel, one word in flight
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= RESP_OKAY;
		end
		else if (ar_go)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_mux;
			rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (S_AXI_RREADY)
			rvalid_ff <= 1'b0;

	// Delineation, correction mode and descrambler
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			st_ff     <= search_state;
			run_ff    <= 3'h0;
			bit_ff    <= 9'h000;
			sr_ff     <= 40'h0000000000;
			mode_ff   <= corr_mode;
			ds_ff     <= '0;
			pay_sr_ff <= 8'h00;
		end
		else
		begin
			st_ff  <= nxt_st;
			run_ff <= nxt_run;
			bit_ff <= nxt_bit;
			if (bit_in)
				sr_ff <= sr_nxt;
			// Mode only means something while locked
			if (st_ff != locked_state)
				mode_ff <= corr_mode;
			else if (at_lock)
				mode_ff <= hdr_err ? detect_mode : corr_mode;
			// Header bits never pass the descrambler
			if (pay_bit)
				ds_ff <= {ds_ff[DESCR_LEN-2:0], LINE_BIT};
			if (pay_bit)
				pay_sr_ff <= {pay_sr_ff[6:0], desc_bit};
		end

	// FIFO write side and counters
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			wact_ff    <= 1'b0;
			wslot_ff   <= 2'h0;
			hdr_q_ff   <= 40'h0000000000;
			hidx_ff    <= HDR_BYTES;
			corr_ff    <= 8'h00;
			uncorr_ff  <= 12'h000;
			cells_ff   <= 16'h0000;
			latched_ff <= 16'h0000;
		end
		else
		begin
			corr_ff   <= corr_w[7:0];
			uncorr_ff <= unc_w[11:0];
			cells_ff  <= cells_w;
			if (w_latch)
				latched_ff <= cells_ff;
			if (start_wr)		// Only locked cells enter
			begin
				wact_ff  <= 1'b1;
				hdr_q_ff <= hdr_fix;
				hidx_ff  <= 3'h0;
			end
			else if (hdr_wr)
			begin
				hdr_q_ff <= {hdr_q_ff[31:0], 8'h00};
				hidx_ff  <= hidx_ff + 3'h1;
			end
			if (commit)
				wslot_ff <= wslot_ff + 2'h1;
			if (commit || nxt_st != locked_state)
				wact_ff <= 1'b0;
		end

	// Occupancy: committed cells not yet read out
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			cnt_ff <= 3'h0;
		else
			cnt_ff <= cnt_ff + {2'h0, commit} - {2'h0, rd_last};

	// Loss of delineation integration
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			pre_ff  <= '0;
			per_ff  <= 16'h0000;
			loss_ff <= 1'b0;
		end
		else
		begin
			pre_ff <= tick ? '0 : pre_ff + PW'(1);
			if (tick && ood == loss_ff)
				per_ff <= 16'h0000;
			else if (flip)		// Same period both ways
			begin
				per_ff  <= 16'h0000;
				loss_ff <= !loss_ff;
			end
			else if (tick)
				per_ff <= per_ff + 16'h0001;
		end

	// Cell bus selection and transfer
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			sel_ff   <= 1'b0;
			poll_ff  <= 1'b0;
			xfer_ff  <= 1'b0;
			hold_ff  <= 1'b0;
			ridx_ff  <= 6'h00;
			rslot_ff <= 2'h0;
			soc_ff   <= 1'b0;
			doe_ff   <= 1'b0;
		end
		else
		begin
			if (UR_ENB_N)		// Address only looked at with enable high
				sel_ff <= addr_me;
			poll_ff <= addr_me;
			hold_ff <= rd_last;	// One-cycle gap after a cell
			soc_ff  <= rd_go && ridx_ff == 6'h00;
			doe_ff  <= rd_go;
			if (rd_go)
			begin
				xfer_ff <= !rd_last;
				ridx_ff <= rd_last ? 6'h00 : ridx_ff + 6'h01;
			end
			if (rd_last)
				rslot_ff <= rslot_ff + 2'h1;
		end

	// Four cells of this port inside the 2k byte store
	acrp_cell_ram u_ram
	(
		.clk		(CLK),
		.rst_n		(RST_N),
		.we		(ram_we),
		.waddr		({MEM_PORT, wslot_ff, widx}),
		.wdata		(wbyte),
		.re		(rd_go),
		.raddr		({MEM_PORT, rslot_ff, ridx_ff}),
		.rdata_ff	(ram_q)
	);

	// Outputs; status held through a transfer, gap after it
	assign UR_CLAV       = xfer_ff || (!hold_ff && avail);
	assign UR_CLAV_OE    = dir_ff || poll_ff;
	assign UR_DATA       = ram_q;
	assign UR_DATA_OE    = doe_ff;
	assign UR_SOC        = soc_ff;
	assign LOSS_IRQ      = chg_ff && ctrl_b_ff[CB_MASK];
	assign S_AXI_AWREADY = wr_go;
	assign S_AXI_WREADY  = wr_go;
	assign S_AXI_BVALID  = bvalid_ff;
	assign S_AXI_BRESP   = bresp_ff;
	assign S_AXI_ARREADY = !rvalid_ff;
	assign S_AXI_RVALID  = rvalid_ff;
	assign S_AXI_RDATA   = rdata_ff;
	assign S_AXI_RRESP   = rresp_ff;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	port_select_a: assert property (UR_ENB_N && addr_me |=> sel_ff)
		else $error("addressed port not selected");
	clav_level_a: assert property (!xfer_ff && !hold_ff && avail |-> UR_CLAV)
		else $error("cell available not shown");
	clav_gap_a: assert property (rd_last |=> !UR_CLAV ##1 (UR_CLAV == avail))
		else $error("cell available gap wrong");
	search_state_found_a: assert property (st_ff == search_state && bit_in && good_now
		|=> st_ff == pre_lock_state && bit_ff == HDR_END)
		else $error("search did not enter pre-lock");
	lock_six_a: assert property (st_ff == pre_lock_state && at_hdr && !hdr_err && run_ff == 3'h5
		|=> st_ff == locked_state)
		else $error("pre-lock did not lock");
	loss_seven_a: assert property (st_ff == locked_state && at_hdr && hdr_err && run_ff == 3'h6
		|=> st_ff == search_state)
		else $error("lock not lost after seven");
	corr_sat_a: assert property (!w_hec |=> corr_ff >= $past(corr_ff))
		else $error("corrected counter wrapped");
	loss_event_a: assert property ($changed(loss_ff) |-> chg_ff)
		else $error("loss change not flagged");
	fifo_gate_a: assert property (wact_ff |-> st_ff == locked_state && cnt_ff < FIFO_CELLS)
		else $error("cell written while unlocked or full");
	xfer_hold_a: assert property (rd_go && !rd_last |=> UR_CLAV [*1] ##0 xfer_ff)
		else $error("cell available dropped mid-cell");
endmodule // acrp_rx_path

//--- tb/acrp_atm_layer.sv
// Behavioural ATM layer: selects one port and pulls whole cells off the cell bus.
// Assumes the bench calls fetch from its own process; outputs change after rising edges.
`timescale 1ns/10ps
module acrp_atm_layer
	(
	input	wire logic		clk,
	input	wire logic		clav,
	input	wire logic [7:0]	data,
	input	wire logic		data_oe,
	input	wire logic		soc,
	output	logic [4:0]		addr = 5'h00,
	output	logic			enb_n = 1'b1
	);
	// Select, wait w extra cycles (slow answer), take 53 bytes, then poll again
	task automatic fetch(input logic [4:0] a, input int w, output logic [7:0] b0, output logic [7:0] bl,
		output logic ok, output logic gap, output logic lvl);
		@(posedge clk);
		addr <= a;	// Address moves only while enable is high
		repeat (w + 1) @(posedge clk);
		enb_n <= 1'b0;
		ok = 1'b1;
		for (int i = 0; i < 53; i++)
		begin
			@(posedge clk);
			if (i == 52)
				enb_n <= 1'b1;	// One cell only, then a rest cycle
			#1;
			ok &= data_oe & (soc == (i == 0)) & (clav | i == 52);
			b0 = (i == 0) ? data : b0;
			bl = data;
		end
		gap = clav;
		@(posedge clk);
		#1;
		lvl = clav;	// Poll only once the transfer is over
	endtask
endmodule // acrp_atm_layer

//--- tb/test_atm_cell_receive_path.sv
// Self-checking bench for the cell receive path: line cells in, cells out over the cell bus.
// Assumes acrp_atm_layer as the ATM layer and a short persistence prescaler.
`timescale 1ns/10ps
module test_atm_cell_receive_path;
	import acrp_pkg::*;
	logic		CLK = 1'b0, RST_N = 1'b0, LINE_BIT = 1'b0, LINE_BIT_VALID = 1'b0;
	logic [4:0]	UR_ADDR;
	logic		UR_ENB_N, UR_CLAV, UR_CLAV_OE, UR_DATA_OE, UR_SOC, LOSS_IRQ;
	logic [7:0]	UR_DATA, S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0]	S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
	logic [3:0]	S_AXI_WSTRB = 4'hF;
	logic [1:0]	S_AXI_BRESP, S_AXI_RRESP, rs;
	logic		S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic		S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic		S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	int		fail_count = 0, samples_checked = 0;
	localparam logic [31:0] HDR = 32'h12345670;	// Assigned, CLP clear

	acrp_rx_path #(.PRESCALE_CYCLES(8)) i_dut (.CLK(CLK), .RST_N(RST_N), .LINE_BIT(LINE_BIT),
		.LINE_BIT_VALID(LINE_BIT_VALID), .UR_ADDR(UR_ADDR), .UR_ENB_N(UR_ENB_N), .UR_CLAV(UR_CLAV),
		.UR_CLAV_OE(UR_CLAV_OE), .UR_DATA(UR_DATA), .UR_DATA_OE(UR_DATA_OE), .UR_SOC(UR_SOC),
		.LOSS_IRQ(LOSS_IRQ), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
	acrp_atm_layer i_atm (.clk(CLK), .clav(UR_CLAV), .data(UR_DATA), .data_oe(UR_DATA_OE),
		.soc(UR_SOC), .addr(UR_ADDR), .enb_n(UR_ENB_N));
	always #5 CLK = ~CLK;

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	// AXI write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do @(negedge CLK); while (S_AXI_AWREADY !== 1'b1 || S_AXI_WREADY !== 1'b1);
		@(posedge CLK);
		S_AXI_AWVALID <= 1'b0;
		S_AXI_WVALID <= 1'b0;
		do @(negedge CLK); while (S_AXI_BVALID !== 1'b1);
		@(posedge CLK);
		rs = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do @(negedge CLK); while (S_AXI_ARREADY !== 1'b1);
		@(posedge CLK);
		S_AXI_ARVALID <= 1'b0;
		do @(negedge CLK); while (S_AXI_RVALID !== 1'b1);
		@(posedge CLK);
		rd = S_AXI_RDATA;
		rs = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask

	// Header check code, MSB first, generator 1+X+X^2+X^8
	function automatic logic [7:0] hec(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	// One 424-bit cell, header bits flipped by f, offset added to the check byte
	task automatic send_cell(input logic [39:0] f);
		logic [423:0] c;
		c = {{HDR, hec(HDR) ^ 8'h55} ^ f, {48{8'h6A}}};
		for (int i = 423; i >= 0; i--)
		begin
			@(posedge CLK);
			LINE_BIT <= c[i];
			LINE_BIT_VALID <= 1'b1;
		end
		@(posedge CLK);
		LINE_BIT_VALID <= 1'b0;
	endtask

	task automatic t_regs();
		rdr(OFF_CTRL_A);
		check(rd, 32'h3);
		rdr(8'h1C);
		check(rs, RESP_SLVERR);
		repeat (200) @(posedge CLK);
		rdr(OFF_STATUS);
		check(rd[2:0], 3'h4);
		check(LOSS_IRQ, 1'b0);
		wr(OFF_CTRL_B, 32'h10);
		check(LOSS_IRQ, 1'b1);
		wr(OFF_STATUS, 32'h08);
		check(LOSS_IRQ, 1'b0);
		$display("test regs done");
	endtask

	task automatic t_lock();
		repeat (7) send_cell(40'h0);
		rdr(OFF_STATUS);
		check(rd[1:0], 2'h2);
		repeat (4) send_cell(40'h0);
		rdr(OFF_STATUS);
		check(rd[3:2], 2'h2);
		check(LOSS_IRQ, 1'b1);
		$display("test lock done");
	endtask

	// Four cells held; first from port 0, the rest from port 31, slower each time
	task automatic t_fetch();
		logic [7:0] b0, bl;
		logic ok, gap, lvl;
		for (int n = 0; n < 4; n++)
		begin
			if (n == 1)
				wr(OFF_PORT, 32'h1F);
			i_atm.fetch((n == 0) ? 5'h00 : 5'h1F, n, b0, bl, ok, gap, lvl);
			check({b0, bl}, {HDR[31:24], 8'h6A});
			check(ok, 1'b1);
			check(gap, 1'b0);
			check(lvl, n < 3);
		end
		check(UR_CLAV_OE, 1'b1);
		wr(OFF_PORT, 32'h0);
		@(posedge CLK);
		check(UR_CLAV_OE, 1'b0);
		wr(OFF_PORT, 32'h100);
		check(UR_CLAV_OE, 1'b1);
		$display("test fetch done");
	endtask

	task automatic t_hec();
		repeat (2) send_cell(40'h1 << 20);
		rdr(OFF_HECCNT);
		check(rd, 32'h00010001);
		repeat (7) send_cell(40'hFF);
		rdr(OFF_STATUS);
		check(rd[1:0] == 2'h2, 1'b0);
		wr(OFF_LATCH, 32'h0);
		rdr(OFF_LATCH);
		check(rd[15:0], 16'h5);
		wr(OFF_LATCH, 32'h0);
		rdr(OFF_LATCH);
		check(rd[15:0], 16'h0);
		$display("test header errors done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		t_regs();
		t_lock();
		t_fetch();
		t_hec();
		conclude();
	end

	// Hang guard, well beyond the expected run
	initial
	begin
		repeat (40000) @(posedge CLK);
		fail_count++;
		conclude();
	end
endmodule // test_atm_cell_receive_path
